// *** core/rpc_pkg.sv ***
// rpc_pkg: constants, enumerations and carriers of the radio power, clock and mode control.
// assumes a single 200 MHz system clock; STAB_CYCLES below is derived from that period.
package rpc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    localparam int unsigned STAB_TIME_US   = 550;
    // least time, so round up
    localparam int unsigned STAB_CYCLES    = (STAB_TIME_US * 1000000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
    localparam int unsigned MARGIN_CYCLES  = 2000;
    localparam int          STAB_W         = 20;
    localparam logic [3:0]  WAKE_SLOW_TICKS = 4'h4;
    localparam logic [3:0]  WAKE_BASE_TICKS = 4'h6;

    // ----------------------------------------------------------------
    // synchroniser lane positions
    // ----------------------------------------------------------------
    localparam int SY_UPE  = 0;
    localparam int SY_RST  = 1;
    localparam int SY_CE   = 2;
    localparam int SY_SEL  = 3;
    localparam int SY_INT  = 4;
    localparam int SY_EXT  = 5;
    localparam int SY_BASE = 6;
    localparam int SY_N    = 7;

    // ----------------------------------------------------------------
    // encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] DIV_OFF = 2'h0;
    localparam logic [1:0] DIV_16M = 2'h1;
    localparam logic [1:0] DIV_8M  = 2'h2;
    localparam logic [1:0] DIV_4M  = 2'h3;
    localparam logic [7:0] RSSI_STRONG_DEF = 8'hB0;
    localparam logic [7:0] RSSI_WEAK_DEF   = 8'h50;

    typedef enum logic [8:0] {
        ST_POWER_DOWN = 9'h001,
        ST_RESET      = 9'h002,
        ST_STANDBY    = 9'h004,
        ST_WAITING    = 9'h008,
        ST_WARMUP     = 9'h010,
        ST_TRANSMIT   = 9'h020,
        ST_RECEIVE    = 9'h040,
        ST_LONG_DORM  = 9'h080,
        ST_SHORT_DORM = 9'h100
    } rpc_state_type;

    typedef enum logic [1:0] {
        PM_LOW    = 2'h0,
        PM_NORMAL = 2'h1,
        PM_HIGH   = 2'h2
    } rpc_pmode_type;

    localparam rpc_state_type STATE_RESET = ST_POWER_DOWN;
    localparam rpc_pmode_type PMODE_RESET = PM_NORMAL;

    typedef struct packed {
        logic       sleep_cmd;
        logic       long_dormant_state_cmd;
        logic       tx_event;
        logic       rx_event;
        logic       warmup_done;
        logic       packet_done;
        logic       rssi_valid;
        logic [7:0] rssi;
    } rpc_evt_type;

    typedef struct packed {
        logic          converter_on;
        logic          base_osc_on;
        logic          base_clock_ready;
        logic          full_reset;
        logic          wake_reset;
        logic          baseband_reset;
        logic          pa_path;
        logic          lna_path;
        logic          wake_release;
        rpc_pmode_type pmode;
    } rpc_ctl_type;

endpackage : rpc_pkg

// *** core/rpc_power_mode_ctrl.sv ***
// rpc_power_mode_ctrl: radio unit power, clock, reset and mode sequencer.
// assumes pins and slow/base clock levels arrive asynchronously; events arrive on clock.
//
// How it works
// [R1] sleep timer counts slow ticks while dormant
// [R2] long dormant wake restores converter, oscillator, baseband reset
// [R3] short dormant wake: no re-power, no reset
// [R4] base clock unusable until stabilization plus margin
// [R5] select low: internal slow oscillator used
// [R6] select high: external slow square wave used
// [R7] divided clock out: off, 16, 8, 4 MHz
// [R8] radio reset low resets internal circuitry, except in dormant, reset and power-down states
// [R9] long dormant wake issues partial wake reset
// [R10] host enables adaptive only as slave
// [R11] adaptive: pick power mode from signal strength
// [R12] adaptive off: fixed normal power mode
// [R13] transmit: warm-up, send, back to waiting
// [R14] receive: warm-up, receive, back to waiting
// [R15] antenna switch routes active path, isolates other
// [R16] switching converter use is selectable
// [R17] power enable low forces power-down
// [R18] reset rise reaches waiting in 4 slow+6 base
// [R19] sleep count reaching duration raises wake release
`timescale 1ns/1ps
module rpc_power_mode_ctrl #(
    parameter int unsigned STAB_CYCLES   = rpc_pkg::STAB_CYCLES,
    parameter int unsigned MARGIN_CYCLES = rpc_pkg::MARGIN_CYCLES,
    parameter int          SLEEP_W       = 24,
    parameter logic [7:0]  RSSI_STRONG   = rpc_pkg::RSSI_STRONG_DEF,
    parameter logic [7:0]  RSSI_WEAK     = rpc_pkg::RSSI_WEAK_DEF
) (
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic                  unit_power_enable,
    input  wire logic                  radio_reset_n,
    input  wire logic                  chip_enable,
    input  wire logic                  slow_clock_source_select,
    input  wire logic                  internal_slow_osc,
    input  wire logic                  external_slow_clock_in,
    input  wire logic                  base_clock_in,
    input  wire logic                  converter_select,
    input  wire logic                  adaptive_enable,
    input  wire logic [1:0]            clkout_select,
    input  wire logic [SLEEP_W-1:0]    sleep_duration,
    input  wire rpc_pkg::rpc_evt_type  evt,
    output rpc_pkg::rpc_ctl_type       ctl,
    output rpc_pkg::rpc_state_type     radio_state,
    output logic                       divided_base_clock_out
);

    localparam int STAB_W_L = rpc_pkg::STAB_W;
    localparam logic [STAB_W_L-1:0] STAB_TOTAL = STAB_W_L'(STAB_CYCLES + MARGIN_CYCLES);

    // ----------------------------------------------------------------
    // synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [rpc_pkg::SY_N-1:0] meta_reg;
    logic [rpc_pkg::SY_N-1:0] sync_reg;
    logic                     slow_prev_reg;
    logic                     base_prev_reg;
    logic                     slow_now;
    logic                     slow_tick;
    logic                     base_tick;

    always_ff @(posedge clock) begin
        meta_reg      <= {base_clock_in, external_slow_clock_in, internal_slow_osc,
                          slow_clock_source_select, chip_enable, radio_reset_n, unit_power_enable};
        sync_reg      <= meta_reg;
        slow_prev_reg <= slow_now;
        base_prev_reg <= sync_reg[rpc_pkg::SY_BASE];
    end

    // source mux picks the slow clock before its edge is taken
    assign slow_now  = sync_reg[rpc_pkg::SY_SEL] ? sync_reg[rpc_pkg::SY_EXT]   // [R6]
                                                 : sync_reg[rpc_pkg::SY_INT];  // [R5]
    assign slow_tick = slow_now & ~slow_prev_reg;
    assign base_tick = sync_reg[rpc_pkg::SY_BASE] & ~base_prev_reg;

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    rpc_pkg::rpc_state_type state_reg,  state_next;
    rpc_pkg::rpc_ctl_type   ctl_reg,    ctl_next;
    logic [STAB_W_L-1:0]    stab_reg,   stab_next;
    logic [SLEEP_W:0]       sleep_reg,  sleep_next;
    logic [3:0]             wslow_reg,  wslow_next;
    logic [3:0]             wbase_reg,  wbase_next;
    logic                   waking_reg, waking_next;
    logic                   dir_tx_reg, dir_tx_next;
    logic [7:0]             rssi_reg,   rssi_next;
    logic [1:0]             div_reg,    div_next;
    logic                   clko_reg,   clko_next;
    logic                   upe, rst_n, ce, osc_on, ready;

    always_comb begin
        upe         = sync_reg[rpc_pkg::SY_UPE];
        rst_n       = sync_reg[rpc_pkg::SY_RST];
        ce          = sync_reg[rpc_pkg::SY_CE];
        state_next  = state_reg;
        stab_next   = stab_reg;
        sleep_next  = sleep_reg;
        wslow_next  = wslow_reg;
        wbase_next  = wbase_reg;
        waking_next = waking_reg;
        dir_tx_next = dir_tx_reg;
        rssi_next   = rssi_reg;
        ctl_next    = ctl_reg;
        ctl_next.wake_reset     = 1'b0;
        ctl_next.baseband_reset = 1'b0;
        ctl_next.wake_release   = 1'b0;
        ctl_next.full_reset     = 1'b0;
        ready = (stab_reg >= STAB_TOTAL);                                      // [R4]

        case (state_reg)
            rpc_pkg::ST_POWER_DOWN: begin
                if (upe) state_next = rpc_pkg::ST_RESET;
            end
            rpc_pkg::ST_RESET: begin
                if (ce) state_next = rpc_pkg::ST_STANDBY;
            end
            rpc_pkg::ST_STANDBY: begin
                if (!ce) begin
                    state_next = rpc_pkg::ST_RESET;
                end else if (!rst_n || !ready) begin
                    wslow_next = 4'h0;
                    wbase_next = 4'h0;
                end else if (wslow_reg < rpc_pkg::WAKE_SLOW_TICKS) begin
                    if (slow_tick) wslow_next = wslow_reg + 4'h1;                  // [R18]
                end else if (wbase_reg < rpc_pkg::WAKE_BASE_TICKS) begin
                    if (base_tick) wbase_next = wbase_reg + 4'h1;                  // [R18]
                end else begin
                    state_next = rpc_pkg::ST_WAITING;
                end
            end
            rpc_pkg::ST_WAITING: begin
                if (evt.tx_event || evt.rx_event) begin
                    state_next  = rpc_pkg::ST_WARMUP;
                    dir_tx_next = evt.tx_event;
                end else if (evt.long_dormant_state_cmd) begin
                    state_next = rpc_pkg::ST_LONG_DORM;
                end else if (evt.sleep_cmd) begin
                    state_next = rpc_pkg::ST_SHORT_DORM;
                end
                sleep_next  = '0;
                waking_next = 1'b0;
            end
            rpc_pkg::ST_WARMUP: begin
                if (evt.warmup_done)
                    state_next = dir_tx_reg ? rpc_pkg::ST_TRANSMIT : rpc_pkg::ST_RECEIVE;
            end
            rpc_pkg::ST_TRANSMIT: begin
                if (evt.packet_done) state_next = rpc_pkg::ST_WAITING;             // [R13]
            end
            rpc_pkg::ST_RECEIVE: begin
                if (evt.rssi_valid) rssi_next = evt.rssi;                          // [R11]
                if (evt.packet_done) begin
                    state_next = rpc_pkg::ST_WAITING;                              // [R14]
                    if (adaptive_enable) begin                                     // [R11]
                        if (rssi_reg >= RSSI_STRONG)    ctl_next.pmode = rpc_pkg::PM_LOW;
                        else if (rssi_reg <= RSSI_WEAK) ctl_next.pmode = rpc_pkg::PM_HIGH;
                        else                            ctl_next.pmode = rpc_pkg::PM_NORMAL;
                    end
                end
            end
            rpc_pkg::ST_LONG_DORM, rpc_pkg::ST_SHORT_DORM: begin
                if (!waking_reg && slow_tick) begin                                // [R1]
                    if (sleep_reg + 1'b1 >= {1'b0, sleep_duration}) begin          // [R19]
                        ctl_next.wake_release = 1'b1;
                        if (state_reg == rpc_pkg::ST_SHORT_DORM)
                            state_next = rpc_pkg::ST_WAITING;                      // [R3]
                        else
                            waking_next = 1'b1;                                    // [R2]
                    end else begin
                        sleep_next = sleep_reg + 1'b1;
                    end
                end else if (waking_reg && ready) begin
                    state_next              = rpc_pkg::ST_WAITING;
                    waking_next             = 1'b0;
                    ctl_next.wake_reset     = 1'b1;                                // [R9]
                    ctl_next.baseband_reset = 1'b1;                                // [R2]
                end
            end
            default: begin
                state_next = rpc_pkg::ST_POWER_DOWN;
            end
        endcase

        // pin reset pulls a next state of standby, waiting, warm-up, transmit or receive back to standby; dormant, reset and power-down next states are left alone
        if (!rst_n && (state_next == rpc_pkg::ST_WAITING || state_next == rpc_pkg::ST_WARMUP
                    || state_next == rpc_pkg::ST_TRANSMIT || state_next == rpc_pkg::ST_RECEIVE
                    || state_next == rpc_pkg::ST_STANDBY)) begin
            state_next          = rpc_pkg::ST_STANDBY;                             // [R8]
            ctl_next.full_reset = 1'b1;                                            // [R8]
        end
        if (!upe) begin
            state_next          = rpc_pkg::ST_POWER_DOWN;                          // [R17]
            waking_next         = 1'b0;
            ctl_next.full_reset = 1'b0;
        end
        if (!adaptive_enable) ctl_next.pmode = rpc_pkg::PM_NORMAL;                 // [R12]

        // oscillator and converter follow the next state so outputs line up with it
        osc_on = !(state_next == rpc_pkg::ST_POWER_DOWN || state_next == rpc_pkg::ST_RESET
                || (state_next == rpc_pkg::ST_LONG_DORM && !waking_next));         // [R2]
        ctl_next.base_osc_on  = osc_on;
        ctl_next.converter_on = osc_on && converter_select;                        // [R16]
        // restart from stop clears the stabilization count
        if (!osc_on)           stab_next = '0;                                     // [R4]
        else if (!ready)       stab_next = stab_reg + 1'b1;
        ctl_next.base_clock_ready = osc_on && ready;                               // [R4]
        ctl_next.pa_path  = (state_next == rpc_pkg::ST_TRANSMIT);                  // [R15]
        ctl_next.lna_path = (state_next == rpc_pkg::ST_RECEIVE);                   // [R15]
    end

    // ----------------------------------------------------------------
    // divided base clock output
    // ----------------------------------------------------------------
    always_comb begin
        div_next  = div_reg;
        clko_next = clko_reg;
        if (base_tick) div_next = div_reg + 2'h1;
        if (clkout_select == rpc_pkg::DIV_OFF || !ctl_reg.base_clock_ready) begin
            clko_next = 1'b0;                                                      // [R7]
            div_next  = 2'h0;
        end else if (base_tick) begin
            case (clkout_select)
                rpc_pkg::DIV_16M: clko_next = ~clko_reg;                           // [R7]
                rpc_pkg::DIV_8M:  clko_next = (div_reg[0] == 1'b0) ? ~clko_reg : clko_reg;
                rpc_pkg::DIV_4M:  clko_next = (div_reg == 2'h0) ? ~clko_reg : clko_reg;
                default:          clko_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_reg  <= rpc_pkg::STATE_RESET;
            ctl_reg    <= '{pmode: rpc_pkg::PMODE_RESET, default: 1'b0};
            stab_reg   <= '0;
            sleep_reg  <= '0;
            wslow_reg  <= 4'h0;
            wbase_reg  <= 4'h0;
            waking_reg <= 1'b0;
            dir_tx_reg <= 1'b0;
            rssi_reg   <= 8'h00;
            div_reg    <= 2'h0;
            clko_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            ctl_reg    <= ctl_next;
            stab_reg   <= stab_next;
            sleep_reg  <= sleep_next;
            wslow_reg  <= wslow_next;
            wbase_reg  <= wbase_next;
            waking_reg <= waking_next;
            dir_tx_reg <= dir_tx_next;
            rssi_reg   <= rssi_next;
            div_reg    <= div_next;
            clko_reg   <= clko_next;
        end
    end

    assign ctl                    = ctl_reg;
    assign radio_state            = state_reg;
    assign divided_base_clock_out = clko_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_power_down_force: assert property (!sync_reg[rpc_pkg::SY_UPE] |=>   // [R17]
        state_reg == rpc_pkg::ST_POWER_DOWN) else $error("power enable low missed");
    a_stab_gate_wait: assert property ($past(state_reg) == rpc_pkg::ST_STANDBY &&   // [R4]
        state_reg == rpc_pkg::ST_WAITING |-> $past(stab_reg) >= STAB_TOTAL)
        else $error("waiting entered before stabilization");
    a_long_wake_reset: assert property ($past(state_reg) == rpc_pkg::ST_LONG_DORM &&   // [R9]
        state_reg == rpc_pkg::ST_WAITING |-> ctl_reg.wake_reset && ctl_reg.baseband_reset)
        else $error("long wake without reset");
    a_short_wake_quiet: assert property ($past(state_reg) == rpc_pkg::ST_SHORT_DORM &&   // [R3]
        state_reg == rpc_pkg::ST_WAITING |-> !ctl_reg.baseband_reset && ctl_reg.base_osc_on)
        else $error("short wake disturbed power");
    a_long_dorm_off: assert property (state_reg == rpc_pkg::ST_LONG_DORM && !waking_reg   // [R2]
        |-> !ctl_reg.converter_on && !ctl_reg.base_osc_on) else $error("long dormant powered");
    a_antenna_route: assert property (state_reg == rpc_pkg::ST_TRANSMIT   // [R15]
        |-> ctl_reg.pa_path && !ctl_reg.lna_path) else $error("antenna path wrong in transmit");
    a_tx_return: assert property (state_reg == rpc_pkg::ST_TRANSMIT && evt.packet_done   // [R13]
        && &sync_reg[rpc_pkg::SY_RST:rpc_pkg::SY_UPE] |=> state_reg == rpc_pkg::ST_WAITING)
        else $error("transmit did not return to waiting");
    a_fixed_normal: assert property ($past(!adaptive_enable) |->   // [R12]
        ctl_reg.pmode == rpc_pkg::PM_NORMAL) else $error("power mode moved while fixed");
    a_clkout_off: assert property (clkout_select == rpc_pkg::DIV_OFF [*2] |->   // [R7]
        !divided_base_clock_out) else $error("divided clock running while off");
    a_pin_reset: assert property (state_reg == rpc_pkg::ST_WAITING   // [R8]
        && !sync_reg[rpc_pkg::SY_RST] && sync_reg[rpc_pkg::SY_UPE] |=> ctl_reg.full_reset)
        else $error("pin reset missed");

    c_tx_cycle:   cover property (state_reg == rpc_pkg::ST_WARMUP ##1
                                  state_reg == rpc_pkg::ST_TRANSMIT);
    c_long_wake:  cover property (ctl_reg.wake_reset);
    c_short_wake: cover property (state_reg == rpc_pkg::ST_SHORT_DORM ##1
                                  state_reg == rpc_pkg::ST_WAITING);
    c_low_power:  cover property (ctl_reg.pmode == rpc_pkg::PM_LOW);

endmodule : rpc_power_mode_ctrl

// *** tb/rf_power_clock_mode_control_bench.sv ***
// rf_power_clock_mode_control_bench: self-checking bench of the power sequencer.
// assumes short stabilization parameters and a fast slow clock from the far side model.
`timescale 1ns/1ps
module rf_power_clock_mode_control_bench;
    logic clock, nrst, unit_power_enable, radio_reset_n, chip_enable, run_int, run_ext;
    logic slow_clock_source_select, converter_select, adaptive_enable, divided_base_clock_out;
    logic internal_slow_osc, external_slow_clock_in, base_clock_in;
    logic [1:0]  clkout_select;
    logic [23:0] sleep_duration;
    logic [3:0]  cmd;
    logic [7:0]  rssi_set;
    rpc_pkg::rpc_evt_type   evt;
    rpc_pkg::rpc_ctl_type   ctl;
    rpc_pkg::rpc_state_type radio_state;
    int err_total = 0, n_tests = 0, tick = 0;
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    rpc_power_mode_ctrl #(.STAB_CYCLES(20), .MARGIN_CYCLES(4)) i_rpc_power_mode_ctrl (
        .clock(clock), .nrst(nrst), .unit_power_enable(unit_power_enable),
        .radio_reset_n(radio_reset_n), .chip_enable(chip_enable),
        .slow_clock_source_select(slow_clock_source_select),
        .internal_slow_osc(internal_slow_osc), .external_slow_clock_in(external_slow_clock_in),
        .base_clock_in(base_clock_in), .converter_select(converter_select),
        .adaptive_enable(adaptive_enable), .clkout_select(clkout_select),
        .sleep_duration(sleep_duration), .evt(evt), .ctl(ctl), .radio_state(radio_state),
        .divided_base_clock_out(divided_base_clock_out));
    rpc_far_side i_rpc_far_side (
        .clock(clock), .radio_state(radio_state), .run_int(run_int), .run_ext(run_ext),
        .cmd(cmd), .rssi_set(rssi_set), .internal_slow_osc(internal_slow_osc),
        .external_slow_clock_in(external_slow_clock_in), .base_clock_in(base_clock_in),
        .evt(evt));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wait_st(input rpc_pkg::rpc_state_type s, input int lim);
        for (int i = 0; i < lim && radio_state !== s; i++) @(negedge clock);
        chk("radio_state", 32'(radio_state), 32'(s));
    endtask : wait_st
    task automatic pulse(input int b);
        @(negedge clock);
        cmd[b] = 1'b1;
        @(negedge clock);
        cmd = 4'h0;
    endtask : pulse
    always @(posedge clock) if (++tick == 20000) begin
        err_total++;
        close_out();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_power;
        int n = 0;
        unit_power_enable = 1'b1;
        wait_st(rpc_pkg::ST_RESET, 10);
        chip_enable = 1'b1;
        wait_st(rpc_pkg::ST_STANDBY, 10);
        chk("osc_on", ctl.base_osc_on, 1);
        chk("conv_on", ctl.converter_on, 1);
        while (ctl.base_clock_ready !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk("stab_wait", 32'(n >= 24 && n < 200), 1);
        wait_st(rpc_pkg::ST_WAITING, 4 * 32 + 6 * 6 + 10);
    endtask : t_power
    task automatic t_tx;
        pulse(1);
        wait_st(rpc_pkg::ST_TRANSMIT, 20);
        chk("pa_lna_tx", {ctl.pa_path, ctl.lna_path}, 2'b10);
        wait_st(rpc_pkg::ST_WAITING, 20);
        chk("pa_idle", ctl.pa_path, 0);
    endtask : t_tx
    task automatic t_rx(input logic [7:0] s, input logic ad, input rpc_pkg::rpc_pmode_type pm);
        adaptive_enable = ad; // slave role assumed whenever enabled
        rssi_set = s;
        pulse(0);
        wait_st(rpc_pkg::ST_RECEIVE, 20);
        chk("pa_lna_rx", {ctl.pa_path, ctl.lna_path}, 2'b01);
        wait_st(rpc_pkg::ST_WAITING, 20);
        repeat (2) @(negedge clock);
        chk("pmode", 32'(ctl.pmode), 32'(pm));
    endtask : t_rx
    task automatic t_dormant(input logic deep);
        int n = 0;
        logic rel = 0, wr = 0, bbr = 0, fr = 0, drop = 0;
        slow_clock_source_select = deep;
        run_int = ~deep; // only the selected source runs
        run_ext = deep;
        // let the source switch settle so no false slow edge counts as sleep
        repeat (4) @(negedge clock);
        pulse(deep ? 2 : 3);
        wait_st(deep ? rpc_pkg::ST_LONG_DORM : rpc_pkg::ST_SHORT_DORM, 5);
        chk("osc_dormant", {ctl.base_osc_on, ctl.converter_on}, deep ? 2'b00 : 2'b11);
        while (radio_state !== rpc_pkg::ST_WAITING && n < 700) begin
            @(negedge clock);
            n++;
            rel |= ctl.wake_release;
            wr |= ctl.wake_reset;
            bbr |= ctl.baseband_reset;
            fr |= ctl.full_reset;
            drop |= ~ctl.base_osc_on;
        end
        chk("sleep_len", 32'(n >= (deep ? 128 : 64) && n < 700), 1);
        chk("wake_release", rel, 1);
        chk("wake_resets", {wr, bbr, fr}, deep ? 3'b110 : 3'b000);
        if (!deep) chk("osc_kept", drop, 0);
    endtask : t_dormant
    task automatic t_pin;
        radio_reset_n = 1'b0;
        wait_st(rpc_pkg::ST_STANDBY, 10);
        chk("full_reset", ctl.full_reset, 1);
        radio_reset_n = 1'b1;
        wait_st(rpc_pkg::ST_WAITING, 4 * 64 + 6 * 6 + 10);
    endtask : t_pin
    task automatic t_clkout;
        int r;
        logic prev;
        for (int k = 0; k < 4; k++) begin
            clkout_select = 2'(k);
            repeat (30) @(negedge clock);
            r = 0;
            prev = divided_base_clock_out;
            repeat (480) begin
                @(negedge clock);
                r += (divided_base_clock_out && !prev) ? 1 : 0;
                prev = divided_base_clock_out;
            end
            r -= (k == 0) ? 0 : (80 >> k);
            chk("clkout_rises", 32'(r >= -1 && r <= 1), 1);
        end
    endtask : t_clkout
    initial begin
        {nrst, unit_power_enable, chip_enable, cmd, clkout_select} = '0;
        {slow_clock_source_select, run_ext, adaptive_enable} = '0;
        {radio_reset_n, run_int, converter_select} = 3'b111;
        sleep_duration = 24'h000003;
        rssi_set = 8'h00;
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        t_power();
        t_tx();
        t_rx(rpc_pkg::RSSI_STRONG_DEF, 1'b1, rpc_pkg::PM_LOW);
        t_rx(8'h80, 1'b1, rpc_pkg::PM_NORMAL);
        t_rx(rpc_pkg::RSSI_WEAK_DEF, 1'b1, rpc_pkg::PM_HIGH);
        t_rx(rpc_pkg::RSSI_STRONG_DEF, 1'b0, rpc_pkg::PM_NORMAL);
        t_dormant(1'b0);
        t_dormant(1'b1);
        converter_select = 1'b0;
        repeat (3) @(negedge clock);
        chk("conv_bypass", ctl.converter_on, 0);
        t_pin();
        t_clkout();
        unit_power_enable = 1'b0;
        wait_st(rpc_pkg::ST_POWER_DOWN, 10);
        close_out();
    end
endmodule : rf_power_clock_mode_control_bench

// *** tb/rpc_far_side.sv ***
// rpc_far_side: host and baseband model around the radio power sequencer.
// assumes the bench drives cmd, rssi_set, run_int and run_ext on the falling edge; all else changes after rising edges.
`timescale 1ns/1ps
module rpc_far_side (
    input  wire logic                   clock,
    input  wire rpc_pkg::rpc_state_type radio_state,
    input  wire logic                   run_int,
    input  wire logic                   run_ext,
    input  wire logic [3:0]             cmd,
    input  wire logic [7:0]             rssi_set,
    output logic                        internal_slow_osc,
    output logic                        external_slow_clock_in,
    output logic                        base_clock_in,
    output rpc_pkg::rpc_evt_type        evt
);
    // ------------------------------------------------------------
    // clock sources
    // ------------------------------------------------------------
    logic [7:0]                  div_reg = 8'h00;
    logic [1:0]                  b_reg   = 2'h0;
    logic [3:0]                  ph_reg  = 4'h0;
    logic                        base_reg = 1'b0;
    rpc_pkg::rpc_state_type      st_reg  = rpc_pkg::ST_POWER_DOWN;
    always_ff @(posedge clock) begin
        div_reg <= div_reg + 8'h01;
        b_reg   <= (b_reg == 2'h2) ? 2'h0 : b_reg + 2'h1;
        if (b_reg == 2'h2) begin
            base_reg <= ~base_reg; // six cycles a period, near the base rate
        end
        ph_reg <= (radio_state == st_reg) ? ph_reg + 4'h1 : 4'h0;
        st_reg <= radio_state;
    end
    assign base_clock_in = base_reg;
    // a stopped slow source stands still low
    assign internal_slow_osc      = run_int & div_reg[4];
    assign external_slow_clock_in = run_ext & div_reg[5];
    // ------------------------------------------------------------
    // baseband events
    // ------------------------------------------------------------
    always_comb begin
        evt             = '0;
        evt.sleep_cmd      = cmd[3];
        evt.long_dormant_state_cmd = cmd[2];
        evt.tx_event       = cmd[1];
        evt.rx_event       = cmd[0];
        evt.warmup_done = (radio_state == rpc_pkg::ST_WARMUP) && (ph_reg == 4'h3);
        evt.packet_done = (radio_state == rpc_pkg::ST_TRANSMIT
                           || radio_state == rpc_pkg::ST_RECEIVE) && (ph_reg == 4'h5);
        evt.rssi_valid  = (radio_state == rpc_pkg::ST_RECEIVE) && (ph_reg == 4'h2);
        // strength is meaningless outside its strobe, so show the inverse there
        evt.rssi        = evt.rssi_valid ? rssi_set : ~rssi_set;
    end
endmodule : rpc_far_side
